// File: ptr_adjust_params.svh
// Purpose: Shared constants of the outbound pointer adjust block.
// Assumes: Register indices are word indices; byte address is index times four.
// Notes: Definitions only.
`ifndef PTR_ADJUST_PARAMS_SVH
`define PTR_ADJUST_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices and reset values
// ----------------------------------------------------------------
`define IDX_CTL 14'h19B7
`define IDX_ARB_HI 14'h19BF
`define IDX_ARB_LO 14'h19C3
`define IDX_PTR_STAT 14'h19C7
`define RST_BYTE 8'h00
`define RST_PTR 10'h000

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BIT_SINGLE_NDF 0
`define BIT_NEG_STUFF 3
`define BIT_POS_STUFF 2
`define BIT_FORCE 5
`define CTL_RW_MASK 8'h32

// ----------------------------------------------------------------
// Pointer word layout and codes
// ----------------------------------------------------------------
`define NDF_NORMAL 4'h6
`define NDF_SET 4'h9
`define I_MASK 10'h2AA
`define D_MASK 10'h155
`define PTR_MAX 10'h30E
`define STUFF_BYTE 8'h00
`define H3_IDLE 8'h00

// ----------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------
`define FRAME_SLOTS 2430
`define SLOT_H1 12'h000
`define SLOT_H2 12'h001
`define SLOT_H3 12'h002
`define SLOT_AFTER_H3 12'h003
`define FIFO_DEPTH 16
`define BYTE_W 8

`endif

// File: ptr_adjust_pkg.sv
// Purpose: Types shared by the outbound pointer adjust block.
// Assumes: Constants come from ptr_adjust_params.svh.
// Notes: Types only.
`include "ptr_adjust_params.svh"

package ptr_adjust_pkg;

  // ----------------------------------------------------------------
  // Pointer action taken in one frame
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ACT_NONE,
    ACT_FORCE,
    ACT_NDF,
    ACT_DEC,
    ACT_INC
  } ptr_action_e;

  // ----------------------------------------------------------------
  // Outbound byte stream
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_start;
    logic [`BYTE_W-1:0] data;
  } tx_byte_s;

endpackage : ptr_adjust_pkg

// File: byte_fifo.sv
// Purpose: Synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; depth is a power of two.
// Notes: Full and empty follow the stored count exactly.
`include "ptr_adjust_params.svh"

module byte_fifo #(
  parameter int WIDTH = `BYTE_W,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("byte_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop, ready_next;

  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_next = push ? wr_reg + AW'(1) : wr_reg;
    rd_next = pop ? rd_reg + AW'(1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    ready_next = (cnt_next != (AW+1)'(DEPTH));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      in_ready <= 1'b1;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
      in_ready <= ready_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

endmodule : byte_fifo

// File: tx_ptr_adjust.sv
// Purpose: Software pointer force, stuff and NDF insertion on the outbound stream.
// Assumes: One byte slot per clock; slots 0, 1, 2 of a frame carry H1, H2, H3.
// Notes: Registers over AHB-Lite, zero wait states, always OKAY.
//
// Our own choice: the AHB-Lite slave port.
`include "ptr_adjust_params.svh"

module tx_ptr_adjust
  import ptr_adjust_pkg::*;
#(
  parameter int FRAME_SLOTS = `FRAME_SLOTS,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Payload bytes in
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic [`BYTE_W-1:0] pay_data,
  // Outbound stream
  output tx_byte_s tx_out
);

  // The slot counter is twelve bits wide and a frame needs room for its header slots.
  if (FRAME_SLOTS < 8 || FRAME_SLOTS > 4095) begin : g_bad_frame
    $error("tx_ptr_adjust frame length out of range");
  end

  // ----------------------------------------------------------------
  // Payload FIFO
  // ----------------------------------------------------------------
  // Payload waits here while the header slots go out.
  logic fifo_valid, fifo_pop;
  logic [`BYTE_W-1:0] fifo_data;

  byte_fifo #(
    .WIDTH(`BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(pay_valid),
    .in_ready(pay_ready),
    .in_data(pay_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic [13:0] idx_reg, idx_next;
  logic [31:0] hrdata_next;
  logic [7:0] ctl_reg, ctl_next, arb_hi_reg, arb_hi_next, arb_lo_reg, arb_lo_next;
  logic [9:0] ptr_reg, ptr_next;
  logic addr_phase, addr_ok;
  logic wr_ctl, set_force, set_pos, set_neg, set_ndf;

  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_ok = (haddr[31:16] == 16'h0000) && (haddr[1:0] == 2'b00);
  assign wr_ctl = wr_pend_reg && (idx_reg == `IDX_CTL);
  // A stored force bit fires only on its rising edge, so rewriting a one is harmless.
  assign set_force = wr_ctl && hwdata[`BIT_FORCE] && !ctl_reg[`BIT_FORCE];
  assign set_pos = wr_ctl && hwdata[`BIT_POS_STUFF];
  assign set_neg = wr_ctl && hwdata[`BIT_NEG_STUFF];
  assign set_ndf = wr_ctl && hwdata[`BIT_SINGLE_NDF];

  // Writes land at the end of the data phase, when hwdata stands; the slave never stalls.
  always_comb begin
    wr_pend_next = addr_phase && hwrite && addr_ok;
    idx_next = addr_phase ? haddr[15:2] : idx_reg;
    hrdata_next = 32'h0000_0000;
    if (addr_phase && !hwrite && addr_ok) begin
      unique case (haddr[15:2])
        `IDX_CTL: hrdata_next = {24'h00_0000, ctl_reg};
        `IDX_ARB_HI: hrdata_next = {24'h00_0000, arb_hi_reg};
        `IDX_ARB_LO: hrdata_next = {24'h00_0000, arb_lo_reg};
        `IDX_PTR_STAT: hrdata_next = {22'h00_0000, ptr_reg};
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
    ctl_next = ctl_reg;
    arb_hi_next = arb_hi_reg;
    arb_lo_next = arb_lo_reg;
    if (wr_pend_reg) begin
      unique case (idx_reg)
        // Pulse bits live only as pending flags, so they read back as zero.
        `IDX_CTL: ctl_next = hwdata[7:0] & `CTL_RW_MASK;
        `IDX_ARB_HI: arb_hi_next = hwdata[7:0];
        `IDX_ARB_LO: arb_lo_next = hwdata[7:0];
        default: ctl_next = ctl_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      idx_reg <= 14'h0000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctl_reg <= `RST_BYTE;
      arb_hi_reg <= `RST_BYTE;
      arb_lo_reg <= `RST_BYTE;
    end else begin
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctl_reg <= ctl_next;
      arb_hi_reg <= arb_hi_next;
      arb_lo_reg <= arb_lo_next;
    end
  end

  // ----------------------------------------------------------------
  // Pending requests and frame action
  // ----------------------------------------------------------------
  logic [11:0] slot_reg, slot_next;
  logic frame_top;
  logic force_pend_reg, force_pend_next, pos_pend_reg, pos_pend_next;
  logic neg_pend_reg, neg_pend_next, ndf_pend_reg, ndf_pend_next;
  ptr_action_e act_reg, act_next, act_new, act_cur;
  logic [1:0] ss_reg, ss_next;

  assign frame_top = (slot_reg == `SLOT_H1);
  assign act_cur = frame_top ? act_new : act_reg;

  always_comb begin
    slot_next = (slot_reg == 12'(FRAME_SLOTS - 1)) ? `SLOT_H1 : slot_reg + 12'h001;
    // One action per frame; force outranks NDF, which outranks the two stuffs.
    act_new = ACT_NONE;
    if (force_pend_reg) begin
      act_new = ACT_FORCE;
    end else if (ndf_pend_reg) begin
      act_new = ACT_NDF;
    end else if (neg_pend_reg) begin
      act_new = ACT_DEC;
    end else if (pos_pend_reg) begin
      act_new = ACT_INC;
    end
    act_next = frame_top ? act_new : act_reg;
    // A new request in the cycle its pending flag is taken stays pending.
    force_pend_next = set_force || (force_pend_reg && !(frame_top && act_new == ACT_FORCE));
    ndf_pend_next = set_ndf || (ndf_pend_reg && !(frame_top && act_new == ACT_NDF));
    neg_pend_next = set_neg || (neg_pend_reg && !(frame_top && act_new == ACT_DEC));
    pos_pend_next = set_pos || (pos_pend_reg && !(frame_top && act_new == ACT_INC));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_reg <= `SLOT_H1;
      act_reg <= ACT_NONE;
      force_pend_reg <= 1'b0;
      ndf_pend_reg <= 1'b0;
      neg_pend_reg <= 1'b0;
      pos_pend_reg <= 1'b0;
    end else begin
      slot_reg <= slot_next;
      act_reg <= act_next;
      force_pend_reg <= force_pend_next;
      ndf_pend_reg <= ndf_pend_next;
      neg_pend_reg <= neg_pend_next;
      pos_pend_reg <= pos_pend_next;
    end
  end

  // ----------------------------------------------------------------
  // Pointer and outbound bytes
  // ----------------------------------------------------------------
  logic [9:0] ptr_word;
  tx_byte_s tx_next;

  always_comb begin
    ptr_next = ptr_reg;
    ss_next = ss_reg;
    ptr_word = ptr_reg;
    fifo_pop = 1'b0;
    tx_next.frame_start = frame_top;
    tx_next.data = fifo_data;
    // The I or D pattern goes out only in H1 and H2 of the adjusting frame.
    if (act_cur == ACT_INC) begin
      ptr_word = ptr_reg ^ `I_MASK;
    end else if (act_cur == ACT_DEC) begin
      ptr_word = ptr_reg ^ `D_MASK;
    end
    unique case (slot_reg)
      `SLOT_H1: begin
        if (act_cur == ACT_FORCE) begin
          tx_next.data = arb_hi_reg;
          ptr_next = {arb_hi_reg[1:0], arb_lo_reg};
          ss_next = arb_hi_reg[3:2];
        end else if (act_cur == ACT_NDF) begin
          tx_next.data = {`NDF_SET, ss_reg, arb_hi_reg[1:0]};
          ptr_next = {arb_hi_reg[1:0], arb_lo_reg};
        end else begin
          tx_next.data = {`NDF_NORMAL, ss_reg, ptr_word[9:8]};
        end
      end
      `SLOT_H2: tx_next.data = ptr_word[7:0];
      // A negative stuff spends one payload byte here.
      `SLOT_H3: begin
        tx_next.data = `H3_IDLE;
        if (act_cur == ACT_DEC) begin
          fifo_pop = 1'b1;
          tx_next.data = fifo_valid ? fifo_data : `H3_IDLE;
        end
      end
      // A positive stuff takes this slot, so the waiting payload byte stays queued.
      // The pointer steps once H1 to H3 are out, so the next frame carries the new value.
      `SLOT_AFTER_H3: begin
        if (act_cur == ACT_INC) begin
          tx_next.data = `STUFF_BYTE;
          ptr_next = (ptr_reg == `PTR_MAX) ? 10'h000 : ptr_reg + 10'h001;
        end else begin
          fifo_pop = 1'b1;
          if (!fifo_valid) begin
            tx_next.data = `STUFF_BYTE;
          end
          if (act_cur == ACT_DEC) begin
            ptr_next = (ptr_reg == 10'h000) ? `PTR_MAX : ptr_reg - 10'h001;
          end
        end
      end
      default: begin
        fifo_pop = 1'b1;
        if (!fifo_valid) begin
          tx_next.data = `STUFF_BYTE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr_reg <= `RST_PTR;
      ss_reg <= 2'b00;
      tx_out <= '0;
    end else begin
      ptr_reg <= ptr_next;
      ss_reg <= ss_next;
      tx_out <= tx_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Stream checks look one cycle after the slot counter, where the registered byte stands.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_FORCE_NDF: assert property (
    frame_top && act_new == ACT_FORCE |=> tx_out.data[7:4] == $past(arb_hi_reg[7:4])
  ) else $error("forced H1 lacks stored NDF bits");
  AST_FORCE_SS: assert property (
    frame_top && act_new == ACT_FORCE |=> ss_reg == $past(arb_hi_reg[3:2]) && tx_out.data[3:2] == ss_reg
  ) else $error("forced H1 lacks stored SS bits");
  AST_FORCE_PTR: assert property (
    frame_top && act_new == ACT_FORCE |=> ##1 ptr_reg == {$past(arb_hi_reg[1:0], 2), $past(arb_lo_reg, 2)}
  ) else $error("forced pointer not loaded");
  AST_POS_STUFF: assert property (
    slot_reg == `SLOT_AFTER_H3 && act_reg == ACT_INC |-> !fifo_pop ##1 tx_out.data == `STUFF_BYTE
  ) else $error("positive stuff byte missing");
  AST_INC_IBITS: assert property (
    slot_reg == `SLOT_H2 && act_reg == ACT_INC |=> tx_out.data == ($past(ptr_reg[7:0]) ^ 8'hAA)
  ) else $error("I bits not inverted");
  AST_INC_PTR: assert property (
    slot_reg == `SLOT_AFTER_H3 && act_reg == ACT_INC && ptr_reg != `PTR_MAX |=> ptr_reg == $past(ptr_reg) + 10'h001
  ) else $error("pointer not incremented");
  AST_NEG_H3: assert property (
    slot_reg == `SLOT_H3 && act_reg == ACT_DEC |-> fifo_pop
  ) else $error("H3 slot not carrying payload");
  AST_DEC_DBITS: assert property (
    slot_reg == `SLOT_H2 && act_reg == ACT_DEC |=> tx_out.data == ($past(ptr_reg[7:0]) ^ 8'h55)
  ) else $error("D bits not inverted");
  AST_DEC_PTR: assert property (
    slot_reg == `SLOT_AFTER_H3 && act_reg == ACT_DEC && ptr_reg != 10'h000 |=> ptr_reg == $past(ptr_reg) - 10'h001
  ) else $error("pointer not decremented");
  AST_SELF_CLEAR: assert property (
    wr_ctl && hwdata[`BIT_POS_STUFF] |=> pos_pend_reg && !ctl_reg[`BIT_POS_STUFF] && !ctl_reg[`BIT_NEG_STUFF]
  ) else $error("stuff bit not self clearing");
  AST_PTR_READ: assert property (
    addr_phase && !hwrite && haddr == {16'h0000, `IDX_PTR_STAT, 2'b00} |=> hrdata[9:0] == $past(ptr_reg)
  ) else $error("pointer readback wrong");
  AST_NDF_CODE: assert property (
    frame_top && act_new == ACT_NDF |=> tx_out.data[7:4] == `NDF_SET
  ) else $error("single NDF code wrong");
  AST_NDF_RESUME: assert property (
    frame_top && act_new != ACT_NDF && act_new != ACT_FORCE |=> tx_out.data[7:4] == `NDF_NORMAL
  ) else $error("NDF bits not back to normal");
  AST_NDF_PTR: assert property (
    frame_top && act_new == ACT_NDF |=> ptr_reg == {$past(arb_hi_reg[1:0]), $past(arb_lo_reg)}
  ) else $error("NDF pointer not loaded");
  AST_NDF_CLEAR: assert property (
    wr_ctl && hwdata[`BIT_SINGLE_NDF] |=> ndf_pend_reg && !ctl_reg[`BIT_SINGLE_NDF]
  ) else $error("NDF bit not self clearing");
  AST_NEG_CLEAR: assert property (
    wr_ctl && hwdata[`BIT_NEG_STUFF] |=> neg_pend_reg && !ctl_reg[`BIT_NEG_STUFF]
  ) else $error("negative stuff bit not self clearing");
  AST_FORCE_EDGE: assert property (
    wr_ctl && hwdata[`BIT_FORCE] && ctl_reg[`BIT_FORCE] |=> !force_pend_reg || $past(force_pend_reg)
  ) else $error("force repeated without a rising edge");
  AST_FRAME_MARK: assert property (
    frame_top |=> tx_out.frame_start
  ) else $error("H1 byte not marked");
  AST_EDGE_ONLY: assert property (
    $fell(pos_pend_reg) |-> $past(frame_top)
  ) else $error("action taken mid frame");

endmodule : tx_ptr_adjust

// File: stream_sink.sv
// Purpose: Far-end receiver model that captures the pointer bytes of each outbound frame.
// Assumes: One byte per clock on tx_out; frame_start marks the H1 byte.
// Notes: Behavioural; it only listens, so no rule of the far side needs driving.
`include "ptr_adjust_params.svh"

module stream_sink
  import ptr_adjust_pkg::*;
#(
  parameter int FRAME_SLOTS = 64
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Stream from the block
  input wire tx_byte_s tx_out,
  // Captured frame bytes
  output logic [7:0] h1,
  output logic [7:0] h2,
  output logic [7:0] h3,
  output logic [7:0] after_h3,
  output logic [7:0] tail,
  output logic [15:0] frame_cnt
);
  int slot;

  // ----------------------------------------------------------------
  // Header capture
  // ----------------------------------------------------------------
  // The count moves once the byte after H3 is in, so a reader sees a whole header.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot <= 0;
      frame_cnt <= 16'h0000;
    end else if (tx_out.frame_start) begin
      slot <= 1;
      h1 <= tx_out.data;
    end else begin
      slot <= slot + 1;
      if (slot == 1) h2 <= tx_out.data;
      if (slot == 2) h3 <= tx_out.data;
      if (slot == 3) begin
        after_h3 <= tx_out.data;
        frame_cnt <= frame_cnt + 16'h0001;
      end
      if (slot == FRAME_SLOTS - 1) tail <= tx_out.data;
    end
  end
endmodule : stream_sink

// File: tx_sts3c_pointer_adjust_ctrl_bench.sv
// Purpose: Self-checking bench of the outbound pointer adjust block.
// Assumes: Zero wait state register bus; 64-slot frames keep the run short.
// Notes: Payload is a steady 0xA5 feed, so stuff bytes and idle bytes stand out.
`include "ptr_adjust_params.svh"

module tx_sts3c_pointer_adjust_ctrl_bench import ptr_adjust_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int FRAME = 64;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic pay_valid = 1'h0;
  logic pay_ready;
  logic [7:0] pay_data = 8'hA5;
  logic feed_en = 1'h0;
  tx_byte_s tx_out;
  logic [7:0] h1, h2, h3, after_h3, tail;
  logic [15:0] frame_cnt;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Design, far end and stimulus clocking
  // ----------------------------------------------------------------
  tx_ptr_adjust #(.FRAME_SLOTS(FRAME), .FIFO_DEPTH(`FIFO_DEPTH)) dut_u (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pay_valid(pay_valid),
    .pay_ready(pay_ready), .pay_data(pay_data), .tx_out(tx_out));
  stream_sink #(.FRAME_SLOTS(FRAME)) sink_u (.hclk(hclk), .hresetn(hresetn), .tx_out(tx_out), .h1(h1),
    .h2(h2), .h3(h3), .after_h3(after_h3), .tail(tail), .frame_cnt(frame_cnt));

  always #50 hclk = ~hclk;

  always @(posedge hclk) begin
    pay_valid <= feed_en;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      $display("Error at %0t: run did not finish", $time);
      results();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One single transfer; the address phase is held until hready, then the data phase likewise.
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {16'h0000, idx, 2'h0};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
    chk(hresp, 32'h00000000, "OKAY response");
  endtask : bus

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [31:0] x;
    bus(1'h1, idx, d, x);
  endtask : wr

  task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] x;
    bus(1'h0, idx, 8'h00, x);
    chk(x, exp, what);
  endtask : rdchk

  task automatic wait_frame();
    logic [15:0] n;
    n = frame_cnt;
    while (frame_cnt === n) @(posedge hclk);
  endtask : wait_frame

  task automatic check_hdr(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3, input logic [7:0] e4);
    chk(h1, e1, "H1 byte");
    chk(h2, e2, "H2 byte");
    chk(h3, e3, "H3 byte");
    chk(after_h3, e4, "byte after H3");
  endtask : check_hdr

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk(`IDX_CTL, 32'h00000000, "control reset");
    rdchk(`IDX_ARB_HI, 32'h00000000, "high reset");
    rdchk(`IDX_ARB_LO, 32'h00000000, "low reset");
    rdchk(`IDX_PTR_STAT, 32'h00000000, "pointer reset");
    wait_frame();
    check_hdr({`NDF_NORMAL, 4'h0}, 8'h00, `H3_IDLE, 8'hA5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    wr(`IDX_CTL, 8'hD2);
    rdchk(`IDX_CTL, 32'h00000012, "control stored bits");
    wr(`IDX_CTL, 8'h00);
    wr(`IDX_ARB_HI, 8'hA5);
    rdchk(`IDX_ARB_HI, 32'h000000A5, "high readback");
    wr(`IDX_ARB_LO, 8'h5A);
    rdchk(`IDX_ARB_LO, 32'h0000005A, "low readback");
    wr(`IDX_PTR_STAT, 8'hFF);
    rdchk(`IDX_PTR_STAT, 32'h00000000, "pointer is read-only");
    wr(`IDX_PTR_STAT + 14'h0001, 8'hFF);
    rdchk(`IDX_PTR_STAT + 14'h0001, 32'h00000000, "unmapped read");
    $display("test registers done");
  endtask : t_regs

  task automatic t_fifo();
    int n;
    n = 0;
    while (pay_ready === 1'h1 && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    chk(pay_ready, 32'h00000000, "fifo refuses when full");
    wait_frame();
    chk(tail, 32'h000000A5, "payload from fifo");
    feed_en <= 1'h0;
    wait_frame();
    wait_frame();
    chk(tail, 32'h00000000, "idle byte when empty");
    chk(pay_ready, 32'h00000001, "fifo accepts when empty");
    feed_en <= 1'h1;
    $display("test fifo done");
  endtask : t_fifo

  task automatic force_ptr(input logic [7:0] hi, input logic [7:0] lo);
    wait_frame();
    wr(`IDX_CTL, 8'h00);
    wr(`IDX_ARB_HI, hi);
    wr(`IDX_ARB_LO, lo);
    wr(`IDX_CTL, 8'h20);
    wr(`IDX_CTL, 8'h20);
    wait_frame();
    check_hdr(hi, lo, `H3_IDLE, 8'hA5);
    rdchk(`IDX_PTR_STAT, {22'h000000, hi[1:0], lo}, "forced pointer");
    $display("test force done");
  endtask : force_ptr

  task automatic stuff_case(input logic inc, input logic [9:0] p);
    logic [9:0] f, n;
    f = p ^ (inc ? `I_MASK : `D_MASK);
    n = inc ? ((p == `PTR_MAX) ? 10'h000 : p + 10'h001) : ((p == 10'h000) ? `PTR_MAX : p - 10'h001);
    force_ptr({`NDF_NORMAL, 2'h1, p[9:8]}, p[7:0]);
    wr(`IDX_CTL, inc ? 8'h04 : 8'h08);
    wait_frame();
    check_hdr({`NDF_NORMAL, 2'h1, f[9:8]}, f[7:0], inc ? `H3_IDLE : 8'hA5, inc ? `STUFF_BYTE : 8'hA5);
    wait_frame();
    check_hdr({`NDF_NORMAL, 2'h1, n[9:8]}, n[7:0], `H3_IDLE, 8'hA5);
    rdchk(`IDX_CTL, 32'h00000000, "stuff bit clears");
    rdchk(`IDX_PTR_STAT, {22'h000000, n}, "pointer after stuff");
    $display("test stuff done");
  endtask : stuff_case

  task automatic t_ndf();
    wait_frame();
    wr(`IDX_ARB_HI, 8'h01);
    wr(`IDX_ARB_LO, 8'h0E);
    wr(`IDX_CTL, 8'h01);
    wait_frame();
    check_hdr({`NDF_SET, 2'h1, 2'h1}, 8'h0E, `H3_IDLE, 8'hA5);
    wait_frame();
    check_hdr({`NDF_NORMAL, 2'h1, 2'h1}, 8'h0E, `H3_IDLE, 8'hA5);
    rdchk(`IDX_CTL, 32'h00000000, "ndf bit clears");
    rdchk(`IDX_PTR_STAT, 32'h0000010E, "pointer after ndf");
    $display("test ndf done");
  endtask : t_ndf

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    feed_en <= 1'h1;
    t_reset();
    t_regs();
    t_fifo();
    force_ptr(8'hA6, 8'h34);
    stuff_case(1'h1, 10'h234);
    stuff_case(1'h0, 10'h234);
    stuff_case(1'h0, 10'h000);
    stuff_case(1'h1, `PTR_MAX);
    t_ndf();
    results();
  end
endmodule : tx_sts3c_pointer_adjust_ctrl_bench
